// ===== rtl/ssdc_pkg.sv
// Purpose: constants for the sync and delay control block
// Assumes: one distribution clock, registers on a plain strobe port
// Notes: offsets are byte addresses of 32-bit words
package ssdc_pkg;
	localparam int NDEV = 2;
	localparam int NSR = 2;
	// register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PULSE = 8'h04;
	localparam logic [7:0] ADDR_SYNCCFG = 8'h08;
	localparam logic [7:0] ADDR_DEVCLK0 = 8'h0c;
	localparam logic [7:0] ADDR_DEVCLK1 = 8'h10;
	localparam logic [7:0] ADDR_SYSREF = 8'h14;
	localparam logic [7:0] ADDR_LOCAL = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_DYNAMIC = 8'h20;
	// control fields
	localparam int CTRL_SYNC_EN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_SRC = 3;
	localparam int CTRL_POL = 5;
	localparam int CTRL_REQ_EN = 6;
	localparam int CTRL_ROUTE = 7;
	localparam int CTRL_ONESHOT = 8;
	localparam int CTRL_SR_PD = 9;
	localparam int CTRL_PLSR_PD = 10;
	localparam int CTRL_GD_PD = 11;
	localparam int CTRL_LCLR = 12;
	// sync configuration fields
	localparam int SCFG_DSB = 0;
	localparam int SCFG_SR_SB = 2;
	localparam int SCFG_DDLY_PD = 3;
	localparam int SCFG_SROUT_PD = 5;
	// device clock fields
	localparam int DEV_DIV = 0;
	localparam int DEV_HIGH = 8;
	localparam int DEV_LOW = 16;
	localparam int DEV_HS = 24;
	localparam int DEV_ANA = 25;
	localparam int DEV_ANA_EN = 30;
	// sysref fields, local fields are one byte per output
	localparam int SR_DIV = 0;
	localparam int SR_GDLY = 16;
	localparam int LOC_DLY = 0;
	localparam int LOC_HS = 4;
	localparam int LOC_SEL = 5;
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_1e80;
	localparam logic [31:0] SCFG_RESET = 32'h0000_0078;
	localparam logic [31:0] DEV_RESET = 32'h0002_0208;
	localparam logic [31:0] SR_RESET = 32'h0000_0008;
	localparam logic [31:0] LOC_RESET = 32'h0000_0000;
	// coarse delay and divider limits
	localparam logic [4:0] HL_MIN = 5'h02;
	localparam logic [4:0] HL_MAX = 5'h10;
	localparam logic [5:0] DIV_MAX = 6'h20;
	localparam logic [12:0] SR_DIV_MIN = 13'h0008;
	localparam logic [3:0] LOC_DLY_MAX = 4'hb;
	// half step is half a distribution period, 250 ps at 2 GHz
	localparam int VCO_PERIOD_PS = 500;
	localparam int HALF_STEP_PS = VCO_PERIOD_PS / 2;
	// analog delay in ps
	localparam logic [10:0] ANA_STEP_PS = 11'h019;
	localparam logic [10:0] ANA_MAX_PS = 11'h23f;
	localparam logic [10:0] ANA_FIXED_PS = 11'h1f4;
	localparam logic [10:0] ANA_MAX_CODE = ANA_MAX_PS / ANA_STEP_PS;
	// trigger modes and sources
	localparam logic [1:0] MODE_0 = 2'h0;
	localparam logic [1:0] MODE_1 = 2'h1;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam logic [1:0] MODE_3 = 2'h3;
	localparam logic [1:0] SRC_DIRECT = 2'h0;
	localparam logic [1:0] SRC_RECLK = 2'h1;
	localparam logic [1:0] SRC_PULSER = 2'h2;
	localparam logic [1:0] SRC_CONT = 2'h3;
	typedef enum logic [1:0] {PL_IDLE, PL_ARMED, PL_RUN} ssdc_pulser_type;

	function automatic logic [5:0] ssdc_clamp_div(input logic [5:0] v);
		if (v == 6'h0)
		begin
			return 6'h1;
		end
		return (v > DIV_MAX) ? DIV_MAX : v;
	endfunction : ssdc_clamp_div

	function automatic logic [4:0] ssdc_clamp_hl(input logic [4:0] v);
		if (v < HL_MIN)
		begin
			return HL_MIN;
		end
		return (v > HL_MAX) ? HL_MAX : v;
	endfunction : ssdc_clamp_hl

	// length of the high phase of an evenly split period
	function automatic logic [12:0] ssdc_half(input logic [12:0] v);
		return v - (v >> 1);
	endfunction : ssdc_half

	function automatic logic [3:0] ssdc_burst_len(input logic [1:0] c);
		return 4'h1 << c;
	endfunction : ssdc_burst_len
endpackage : ssdc_pkg

// ===== rtl/ssdc_top.sv
// Purpose: sync source selection, pulser and digital delays
// Assumes: mclk stands in for the distribution clock
// Notes: half steps and analog delays leave as settings for the output stage
// Operation
// - device clock groups get a coarse delay of 4 to 32 clock cycles
// - half-step option refines coarse delay to half a distribution period
// - new coarse delay values only act after a sync event or a dynamic delay request
// - analog delay 25 ps steps up to 575 ps, plus fixed 500 ps when enabled
// - fixed delay use puts all outputs in known phase on sync
// - dynamic delay use shifts phase while clocks keep running
// - shared sysref divider has its own global delay stage
// - each sysref output has local delay 0 to 11 cycles with half step
// - device clock half step or analog delay changes never glitch the output
// - sync gives all active outputs a common edge plus their fixed delay
// - divider is reset by chosen sync source only when its block bit clear
// - with route select 1, mode 0 source 0 gives no sync; mode 1 source 0 is pin or polarity toggle
// - route select 0 makes reference input zero the sync input in modes 0 and 1 with source 0 or 1
// - mode 2 source 2 pin transition or polarity toggle fires a burst
// - mode 3 source 2 every burst count write fires a burst
// - mode 1 source 1 with route select 1 gives sync re-clocked to sysref frames
// - mode 0 source 2 with request enable runs sysref while pin asserted
// - source 3 gives continuous sysref whatever the mode
// - direct mode fans reference zero out without re-clocking
// - burst length selects 1, 2, 4 or 8 pulses
// - substitute high and low counts 2 to 16 each, sum 4 to 32
`timescale 1ns/1ps
module ssdc_top
	import ssdc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sync_pin,
	input wire logic ref_zero_in,
	output logic [NDEV-1:0] device_clock_output,
	output logic [NDEV-1:0] devclk_half_step,
	output logic [NDEV*11-1:0] devclk_analog_delay_ps,
	output logic [NSR-1:0] sysref_clock_output,
	output logic [NSR-1:0] local_sysref_half_step
);
	logic [31:0] ctrl, synccfg, sysref_cfg, local_cfg;
	logic [31:0] devclk_cfg [NDEV];
	logic [1:0] burst_pulse_count;
	logic count_write;
	logic [NDEV-1:0] dyn_req;
	logic [1:0] trigger_mode, sysref_source;
	logic sync_enable, sync_pin_polarity, sysref_request_enable, ref_zero_route_select;
	logic one_shot_sync_enable, sysref_block_powerdown, pulser_powerdown;
	logic global_sysref_delay_powerdown, local_delay_clear, sysref_divider_sync_block;
	logic [NDEV-1:0] divider_sync_block, devclk_delay_powerdown;
	logic [NSR-1:0] sysref_output_powerdown;

	assign sync_enable = ctrl[CTRL_SYNC_EN];
	assign trigger_mode = ctrl[CTRL_MODE +: 2];
	assign sysref_source = ctrl[CTRL_SRC +: 2];
	assign sync_pin_polarity = ctrl[CTRL_POL];
	assign sysref_request_enable = ctrl[CTRL_REQ_EN];
	assign ref_zero_route_select = ctrl[CTRL_ROUTE];
	assign one_shot_sync_enable = ctrl[CTRL_ONESHOT];
	assign sysref_block_powerdown = ctrl[CTRL_SR_PD];
	assign pulser_powerdown = ctrl[CTRL_PLSR_PD];
	assign global_sysref_delay_powerdown = ctrl[CTRL_GD_PD];
	assign local_delay_clear = ctrl[CTRL_LCLR];
	assign divider_sync_block = synccfg[SCFG_DSB +: NDEV];
	assign sysref_divider_sync_block = synccfg[SCFG_SR_SB];
	assign devclk_delay_powerdown = synccfg[SCFG_DDLY_PD +: NDEV];
	assign sysref_output_powerdown = synccfg[SCFG_SROUT_PD +: NSR];
	assign count_write = wr && (addr == ADDR_PULSE);
	assign dyn_req = (wr && (addr == ADDR_DYNAMIC)) ? wdata[NDEV-1:0] : '0;

	////////////////////////////////////////////////////////////////////////////
	// register port
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			ctrl <= CTRL_RESET;
			synccfg <= SCFG_RESET;
			sysref_cfg <= SR_RESET;
			local_cfg <= LOC_RESET;
			burst_pulse_count <= 2'h0;
			devclk_cfg[0] <= DEV_RESET;
			devclk_cfg[1] <= DEV_RESET;
		end
		else if (wr)
		begin
			case (addr)
				ADDR_CTRL: ctrl <= wdata;
				ADDR_PULSE: burst_pulse_count <= wdata[1:0];
				ADDR_SYNCCFG: synccfg <= wdata;
				ADDR_DEVCLK0: devclk_cfg[0] <= wdata;
				ADDR_DEVCLK1: devclk_cfg[1] <= wdata;
				ADDR_SYSREF: sysref_cfg <= wdata;
				ADDR_LOCAL: local_cfg <= wdata;
				default: ;
			endcase
		end
	end

	logic [31:0] status;
	ssdc_pulser_type pl_state;
	logic req_gate, reclk_lvl, sync_lvl, pin_level;
	assign status = {27'h0, pl_state != PL_IDLE, req_gate, reclk_lvl, sync_lvl, pin_level};

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!reset_n || !rd)
		begin
			rdata <= 32'h0;
		end
		else
		begin
			case (addr)
				ADDR_CTRL: rdata <= ctrl;
				ADDR_PULSE: rdata <= {30'h0, burst_pulse_count};
				ADDR_SYNCCFG: rdata <= synccfg;
				ADDR_DEVCLK0: rdata <= devclk_cfg[0];
				ADDR_DEVCLK1: rdata <= devclk_cfg[1];
				ADDR_SYSREF: rdata <= sysref_cfg;
				ADDR_LOCAL: rdata <= local_cfg;
				ADDR_STATUS: rdata <= status;
				default: rdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sync front end
	logic [1:0] pin_sync, ref_sync;
	logic pin_level_d, ref_level_d, reclk_lvl_d, pin_edge, ref_edge, sync_edge, sync_hold;
	logic sr_tick, sr_wave;
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pin_sync <= 2'h0;
			ref_sync <= 2'h0;
			pin_level_d <= 1'b0;
			ref_level_d <= 1'b0;
			reclk_lvl <= 1'b0;
			reclk_lvl_d <= 1'b0;
		end
		else
		begin
			pin_sync <= {pin_sync[0], sync_pin};
			ref_sync <= {ref_sync[0], ref_zero_in};
			pin_level_d <= pin_level;
			ref_level_d <= ref_sync[1];
			reclk_lvl_d <= reclk_lvl;
			// pin level re-taken on frame boundary
			if (sr_tick)
			begin
				reclk_lvl <= pin_level;
			end
		end
	end
	// polarity toggle acts as a software sync
	assign pin_level = pin_sync[1] ^ sync_pin_polarity;
	assign pin_edge = pin_level && !pin_level_d;
	assign ref_edge = ref_sync[1] && !ref_level_d;

	// source mux, no sync in mode 0 source 0 while route select is 1
	always_comb
	begin
		sync_lvl = 1'b0;
		sync_edge = 1'b0;
		if (!ref_zero_route_select && trigger_mode <= MODE_1 && sysref_source <= SRC_RECLK)
		begin
			sync_lvl = ref_sync[1];
			sync_edge = ref_edge;
		end
		else if (trigger_mode == MODE_1 && sysref_source == SRC_DIRECT)
		begin
			sync_lvl = pin_level;
			sync_edge = pin_edge;
		end
		else if (trigger_mode == MODE_1 && sysref_source == SRC_RECLK)
		begin
			sync_lvl = reclk_lvl;
			sync_edge = reclk_lvl && !reclk_lvl_d;
		end
	end
	// nothing resets without the global enable
	assign sync_hold = sync_enable && (one_shot_sync_enable ? sync_edge : sync_lvl);

	////////////////////////////////////////////////////////////////////////////
	// device clock dividers with substitute delay period
	logic [5:0] dcnt [NDEV];
	logic [5:0] sub_cnt [NDEV];
	logic [5:0] dev_div [NDEV];
	logic [5:0] dev_half [NDEV];
	logic [4:0] act_high [NDEV];
	logic [4:0] act_low [NDEV];
	logic [NDEV-1:0] sub_mode, dyn_pend, dev_reset;
	logic [10:0] next_ana [NDEV];
	logic [12:0] half_tmp [NDEV];
	logic [4:0] ana_code [NDEV];

	always_comb
	begin
		for (int i = 0; i < NDEV; i++)
		begin
			dev_div[i] = ssdc_clamp_div(devclk_cfg[i][DEV_DIV +: 6]);
			half_tmp[i] = ssdc_half({7'h0, dev_div[i]});
			dev_half[i] = half_tmp[i][5:0];
			dev_reset[i] = sync_hold && !divider_sync_block[i];
			ana_code[i] = devclk_cfg[i][DEV_ANA +: 5];
			if ({6'h0, ana_code[i]} > ANA_MAX_CODE)
			begin
				ana_code[i] = ANA_MAX_CODE[4:0];
			end
			next_ana[i] = devclk_cfg[i][DEV_ANA_EN] ?
				{6'h0, ana_code[i]} * ANA_STEP_PS + ANA_FIXED_PS : 11'h0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NDEV; i++)
			begin
				dcnt[i] <= 6'h0;
				sub_cnt[i] <= 6'h0;
				act_high[i] <= HL_MIN;
				act_low[i] <= HL_MIN;
			end
			sub_mode <= '0;
			dyn_pend <= '0;
			device_clock_output <= '0;
		end
		else
		begin
			for (int i = 0; i < NDEV; i++)
			begin
				// sync holds output low, then common restart
				if (dev_reset[i])
				begin
					dcnt[i] <= 6'h0;
					sub_cnt[i] <= 6'h0;
					sub_mode[i] <= !devclk_delay_powerdown[i];
					act_high[i] <= ssdc_clamp_hl(devclk_cfg[i][DEV_HIGH +: 5]);
					act_low[i] <= ssdc_clamp_hl(devclk_cfg[i][DEV_LOW +: 5]);
					dyn_pend[i] <= 1'b0;
					device_clock_output[i] <= 1'b0;
				end
				else if (sub_mode[i])
				begin
					// substitute period of high plus low
					device_clock_output[i] <= sub_cnt[i] < {1'b0, act_high[i]};
					if (sub_cnt[i] == {1'b0, act_high[i]} + {1'b0, act_low[i]} - 6'h1)
					begin
						sub_mode[i] <= 1'b0;
						sub_cnt[i] <= 6'h0;
						dcnt[i] <= 6'h0;
					end
					else
					begin
						sub_cnt[i] <= sub_cnt[i] + 6'h1;
					end
				end
				else
				begin
					device_clock_output[i] <= dcnt[i] < dev_half[i];
					if (dcnt[i] == dev_div[i] - 6'h1)
					begin
						dcnt[i] <= 6'h0;
						if (dyn_pend[i])
						begin
							sub_mode[i] <= 1'b1;
							dyn_pend[i] <= 1'b0;
							act_high[i] <= ssdc_clamp_hl(devclk_cfg[i][DEV_HIGH +: 5]);
							act_low[i] <= ssdc_clamp_hl(devclk_cfg[i][DEV_LOW +: 5]);
						end
					end
					else
					begin
						dcnt[i] <= dcnt[i] + 6'h1;
					end
					if (dyn_req[i] && !devclk_delay_powerdown[i])
					begin
						dyn_pend[i] <= 1'b1;
					end
				end
			end
		end
	end

	// settings change only while the output is low
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			devclk_half_step <= '0;
			devclk_analog_delay_ps <= '0;
		end
		else
		begin
			for (int i = 0; i < NDEV; i++)
			begin
				if (!device_clock_output[i])
				begin
					devclk_half_step[i] <= devclk_cfg[i][DEV_HS];
					devclk_analog_delay_ps[i*11 +: 11] <= next_ana[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared sysref divider with global delay
	logic [12:0] sr_cnt, sr_div, sr_half;
	logic [7:0] gd_cnt;
	logic sr_run;
	// divider stops while its block is powered down
	assign sr_run = !sysref_block_powerdown;
	assign sr_div = (sysref_cfg[SR_DIV +: 13] < SR_DIV_MIN) ? SR_DIV_MIN : sysref_cfg[SR_DIV +: 13];
	assign sr_half = ssdc_half(sr_div);
	assign sr_tick = sr_run && gd_cnt == 8'h0 && sr_cnt == 13'h0;
	assign sr_wave = sr_run && gd_cnt == 8'h0 && sr_cnt < sr_half;

	always_ff @(posedge mclk)
	begin
		if (!reset_n || !sr_run)
		begin
			sr_cnt <= 13'h0;
			gd_cnt <= 8'h0;
		end
		else if (sync_hold && !sysref_divider_sync_block)
		begin
			sr_cnt <= 13'h0;
			gd_cnt <= global_sysref_delay_powerdown ? 8'h0 : sysref_cfg[SR_GDLY +: 8];
		end
		else if (gd_cnt != 8'h0)
		begin
			gd_cnt <= gd_cnt - 8'h1;
		end
		else
		begin
			sr_cnt <= (sr_cnt == sr_div - 13'h1) ? 13'h0 : sr_cnt + 13'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pulser and request gating, whole periods unless a running burst is re-triggered mid-period
	logic [3:0] pl_left;
	logic pl_trig, gate_now, gate_req, request_mode;
	assign pl_trig = !pulser_powerdown && sysref_source == SRC_PULSER &&
		((trigger_mode == MODE_2 && pin_edge) || (trigger_mode == MODE_3 && count_write));
	assign gate_now = (pl_state == PL_ARMED && sr_tick) ||
		(pl_state == PL_RUN && !(sr_tick && pl_left == 4'h0));
	assign request_mode = trigger_mode == MODE_0 && sysref_source == SRC_PULSER &&
		sysref_request_enable;
	assign gate_req = sr_tick ? pin_level : req_gate;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pl_state <= PL_IDLE;
			pl_left <= 4'h0;
		end
		else if (pl_trig)
		begin
			pl_state <= PL_ARMED;
			// 1, 2, 4 or 8 pulses
			pl_left <= ssdc_burst_len(count_write ? wdata[1:0] : burst_pulse_count);
		end
		else
		begin
			case (pl_state)
				PL_ARMED:
				begin
					if (sr_tick)
					begin
						pl_state <= PL_RUN;
						pl_left <= pl_left - 4'h1;
					end
				end
				PL_RUN:
				begin
					if (sr_tick && pl_left == 4'h0)
					begin
						pl_state <= PL_IDLE;
					end
					else if (sr_tick)
					begin
						pl_left <= pl_left - 4'h1;
					end
				end
				default: pl_state <= PL_IDLE;
			endcase
		end
	end

	// request gate moves only at period start
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			req_gate <= 1'b0;
		end
		else if (sr_tick)
		begin
			req_gate <= pin_level;
		end
	end

	logic stream, direct_fanout;
	assign direct_fanout = trigger_mode == MODE_0 && sysref_source == SRC_DIRECT &&
		!ref_zero_route_select && sysref_block_powerdown && pulser_powerdown &&
		global_sysref_delay_powerdown;

	always_comb
	begin
		case (sysref_source)
			SRC_DIRECT: stream = direct_fanout && ref_zero_in;
			SRC_RECLK: stream = sr_wave;
			SRC_PULSER: stream = sr_wave && (request_mode ? gate_req : gate_now);
			SRC_CONT: stream = sr_wave;
			default: stream = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// local sysref delay shift buffers
	logic [10:0] ld_shift [NSR];
	logic [3:0] ld_tap [NSR];
	logic [NSR-1:0] ld_val;

	always_comb
	begin
		for (int i = 0; i < NSR; i++)
		begin
			ld_tap[i] = local_cfg[i*8 + LOC_DLY +: 4];
			if (ld_tap[i] > LOC_DLY_MAX)
			begin
				ld_tap[i] = LOC_DLY_MAX;
			end
			ld_val[i] = (ld_tap[i] == 4'h0) ? stream : ld_shift[i][ld_tap[i] - 4'h1];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NSR; i++)
			begin
				ld_shift[i] <= 11'h0;
			end
			sysref_clock_output <= '0;
			local_sysref_half_step <= '0;
		end
		else
		begin
			for (int i = 0; i < NSR; i++)
			begin
				// buffer held empty while clear is set
				ld_shift[i] <= local_delay_clear ? 11'h0 : {ld_shift[i][9:0], stream};
				local_sysref_half_step[i] <= local_cfg[i*8 + LOC_HS];
				if (sysref_output_powerdown[i])
				begin
					sysref_clock_output[i] <= 1'b0;
				end
				else
				begin
					sysref_clock_output[i] <= local_cfg[i*8 + LOC_SEL] ? ld_val[i] :
						device_clock_output[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_sync_forces_low: assert property (dev_reset[0] |=> !device_clock_output[0])
		else $error("device clock not low after sync");
	a_block_ignores_sync: assert property (
		(sync_hold && divider_sync_block[0] && !sub_mode[0] && !dyn_pend[0]) |=> !sub_mode[0])
		else $error("blocked divider took sync");
	a_delay_shadow_held: assert property (
		(!dev_reset[0] && !(dyn_pend[0] && !sub_mode[0])) |=> $stable(act_high[0]))
		else $error("coarse delay changed without sync");
	a_half_step_glitchless: assert property (
		$changed(devclk_half_step[0]) |-> !$past(device_clock_output[0]))
		else $error("half step changed while output high");
	a_analog_range: assert property (
		devclk_analog_delay_ps[10:0] == 11'h0 ||
		(devclk_analog_delay_ps[10:0] >= ANA_FIXED_PS &&
		devclk_analog_delay_ps[10:0] <= ANA_FIXED_PS + ANA_MAX_PS))
		else $error("analog delay out of range");
	a_pulser_pin_start: assert property (
		(pin_edge && trigger_mode == MODE_2 && sysref_source == SRC_PULSER && !pulser_powerdown)
		|=> pl_state == PL_ARMED)
		else $error("pin transition did not arm pulser");
	a_burst_write_len: assert property (
		(count_write && trigger_mode == MODE_3 && sysref_source == SRC_PULSER &&
		!pulser_powerdown) |=> pl_left == ssdc_burst_len($past(wdata[1:0])))
		else $error("burst length not loaded");
	a_request_no_runt: assert property ($changed(req_gate) |-> $past(sr_tick))
		else $error("request gate moved mid period");
	a_continuous_out: assert property (
		sysref_source == SRC_CONT |-> stream == sr_wave)
		else $error("continuous sysref not passed");
	a_local_bypass: assert property (
		(ld_tap[0] == 4'h0 && local_cfg[LOC_SEL] && !sysref_output_powerdown[0] &&
		$stable(local_cfg) && $stable(synccfg)) |=> sysref_clock_output[0] == $past(stream))
		else $error("bypassed local delay wrong");
	a_substitute_bound: assert property (
		sub_mode[0] |-> sub_cnt[0] < {1'b0, act_high[0]} + {1'b0, act_low[0]})
		else $error("substitute count overran");

	c_burst_done: cover property (pl_state == PL_RUN ##1 pl_state == PL_IDLE);
	c_request_on: cover property ($rose(req_gate));
	c_dynamic_shift: cover property ($rose(sub_mode[0]) && !$past(dev_reset[0]));
endmodule : ssdc_top

// ===== verification/ssdc_receiver.sv
// Purpose: far-side receiver that counts sysref rising edges
// Assumes: sampled on the distribution clock
// Notes: count is cleared on request before each burst
`timescale 1ns/1ps
module ssdc_receiver
(
	input wire logic mclk,
	input wire logic clear,
	input wire logic sysref,
	output logic [7:0] edges
);
	logic last;
	always_ff @(posedge mclk)
	begin
		last <= sysref;
		if (clear)
		begin
			edges <= 8'h00;
		end
		else if (sysref && !last)
		begin
			edges <= edges + 8'h01;
		end
	end
endmodule : ssdc_receiver

// ===== verification/ssdc_top_test.sv
// Purpose: self-checking bench for the sync and delay control block
// Assumes: registers reached over the plain strobe port
// Notes: reference input zero driven only in the sync and fan-out scenarios
`timescale 1ns/1ps
module ssdc_top_test;
	import ssdc_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sync_pin = 1'b0;
	logic ref_zero = 1'b0;
	logic clear = 1'b1;
	logic [31:0] rdata;
	logic [1:0] dco, dhs, sro, lhs;
	logic [21:0] ana;
	logic [7:0] edges;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	ssdc_top u_ssdc_top (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sync_pin(sync_pin), .ref_zero_in(ref_zero),
		.device_clock_output(dco), .devclk_half_step(dhs), .devclk_analog_delay_ps(ana),
		.sysref_clock_output(sro), .local_sysref_half_step(lhs));
	ssdc_receiver u_ssdc_receiver (.mclk(mclk), .clear(clear), .sysref(sro[0]), .edges(edges));
	always #12.5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask : rd_chk
	task automatic run_len(input int k, input logic lvl, output int n);
		n = 0;
		while (dco[k] === lvl && n < 64)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask : run_len
	// count sysref edges over ten whole periods after settling
	task automatic edge_chk(input string what, input logic [31:0] exp);
		repeat (20) @(posedge mclk);
		clear <= 1'b1;
		@(posedge mclk);
		clear <= 1'b0;
		repeat (80) @(posedge mclk);
		#1;
		chk(what, exp, {24'h0, edges});
	endtask : edge_chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////
	task automatic t_reset_regs;
		rd_chk("ctrl", ADDR_CTRL, CTRL_RESET);
		rd_chk("synccfg", ADDR_SYNCCFG, SCFG_RESET);
		rd_chk("devclk0", ADDR_DEVCLK0, DEV_RESET);
		rd_chk("unmapped", 8'h40, 32'h0);
	endtask : t_reset_regs
	task automatic t_fixed_delay;
		int n, hi, lo;
		// sync enabled before use, delay and block bits cleared
		wr_reg(ADDR_CTRL, 32'h0000_0083);
		wr_reg(ADDR_SYNCCFG, 32'h0);
		wr_reg(ADDR_DEVCLK0, 32'h0005_0408);
		@(posedge mclk);
		sync_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		chk("held low", 32'h0, {31'h0, dco[0]});
		@(posedge mclk);
		sync_pin <= 1'b0;
		#1;
		run_len(0, 1'b0, n);
		run_len(0, 1'b1, hi);
		run_len(0, 1'b0, lo);
		chk("subst high", 32'd4, hi);
		chk("subst low", 32'd5, lo);
		run_len(0, 1'b1, hi);
		chk("normal high", 32'd4, hi);
	endtask : t_fixed_delay
	task automatic t_analog;
		wr_reg(ADDR_DEVCLK0, 32'h4705_0408);
		repeat (20) @(posedge mclk);
		#1;
		chk("analog ps", 32'h23f, {21'h0, ana[10:0]});
		chk("half step", 32'h1, {31'h0, dhs[0]});
	endtask : t_analog
	task automatic t_burst;
		// clear held for 15 cycles after power-up
		wr_reg(ADDR_CTRL, 32'h0000_1097);
		repeat (15) @(posedge mclk);
		wr_reg(ADDR_CTRL, 32'h0000_0097);
		wr_reg(ADDR_LOCAL, 32'h0000_0020);
		for (int c = 0; c < 4; c++)
		begin
			clear <= 1'b1;
			@(posedge mclk);
			clear <= 1'b0;
			wr_reg(ADDR_PULSE, c);
			repeat (150) @(posedge mclk);
			#1;
			chk("burst edges", 32'h1 << c, {24'h0, edges});
		end
	endtask : t_burst
	task automatic t_pin_burst;
		wr_reg(ADDR_CTRL, 32'h0000_0095);
		wr_reg(ADDR_PULSE, 32'h0000_0001);
		clear <= 1'b1;
		@(posedge mclk);
		clear <= 1'b0;
		sync_pin <= 1'b1;
		repeat (150) @(posedge mclk);
		#1;
		chk("pin burst", 32'h2, {24'h0, edges});
		@(posedge mclk);
		sync_pin <= 1'b0;
		repeat (10) @(posedge mclk);
		clear <= 1'b1;
		@(posedge mclk);
		clear <= 1'b0;
		wr_reg(ADDR_CTRL, 32'h0000_00b5);
		repeat (150) @(posedge mclk);
		#1;
		chk("toggle burst", 32'h2, {24'h0, edges});
		wr_reg(ADDR_CTRL, 32'h0000_0095);
	endtask : t_pin_burst
	task automatic t_block_ref;
		int n, hi;
		logic seen;
		wr_reg(ADDR_SYNCCFG, 32'h0000_0001);
		wr_reg(ADDR_CTRL, 32'h0000_0083);
		seen = 1'b0;
		@(posedge mclk);
		sync_pin <= 1'b1;
		repeat (16)
		begin
			@(posedge mclk);
			#1;
			seen = seen | dco[0];
		end
		chk("blocked runs", 32'h1, {31'h0, seen});
		chk("unblocked low", 32'h0, {31'h0, dco[1]});
		@(posedge mclk);
		sync_pin <= 1'b0;
		#1;
		run_len(1, 1'b0, n);
		run_len(1, 1'b1, hi);
		chk("dev1 subst high", 32'd2, hi);
		wr_reg(ADDR_SYNCCFG, 32'h0);
		wr_reg(ADDR_CTRL, 32'h0000_0003);
		@(posedge mclk);
		ref_zero <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		chk("ref sync low", 32'h0, {31'h0, dco[0]});
		@(posedge mclk);
		ref_zero <= 1'b0;
		#1;
		run_len(0, 1'b0, n);
		run_len(0, 1'b1, hi);
		chk("ref subst high", 32'd4, hi);
	endtask : t_block_ref
	task automatic t_stream;
		wr_reg(ADDR_LOCAL, 32'h0000_0035);
		wr_reg(ADDR_CTRL, 32'h0000_0099);
		edge_chk("continuous", 32'd10);
		chk("local half step", 32'h1, {31'h0, lhs[0]});
		wr_reg(ADDR_CTRL, 32'h0000_00d1);
		@(posedge mclk);
		sync_pin <= 1'b1;
		edge_chk("request on", 32'd10);
		@(posedge mclk);
		sync_pin <= 1'b0;
		edge_chk("request off", 32'd0);
		wr_reg(ADDR_LOCAL, 32'h0000_0020);
		wr_reg(ADDR_CTRL, 32'h0000_0e01);
		@(posedge mclk);
		ref_zero <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("fanout high", 32'h1, {31'h0, sro[0]});
		@(posedge mclk);
		ref_zero <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("fanout low", 32'h0, {31'h0, sro[0]});
	endtask : t_stream
	////////////////////////////////////////////////////////////////
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			end_sim();
		end
	end
	initial
	begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset_regs();
		t_fixed_delay();
		t_analog();
		t_burst();
		t_pin_burst();
		t_block_ref();
		t_stream();
		end_sim();
	end
endmodule : ssdc_top_test
